// file: hw/sqs_pkg.sv
// Purpose: Shared constants and types for the signal quality status registers
// Assumes: AXI4-Lite, 32-bit data, word index times four gives the byte address
// Notes:   Parameter index 0..4: equalizer, gain, baseline, freq offset, freq control
package sqs_pkg;

  localparam int          SQS_AW          = 8;
  localparam int          SQS_NPARAM      = 5;
  localparam int          SQS_PW          = 8;

  // Register word indices
  localparam logic [5:0]  SQS_IDX_VAR_CTRL = 6'h1a;
  localparam logic [5:0]  SQS_IDX_VAR_WIN  = 6'h1b;
  localparam logic [5:0]  SQS_IDX_LQM      = 6'h1d;
  localparam logic [5:0]  SQS_IDX_IRQ_STAT = 6'h20;
  localparam logic [5:0]  SQS_IDX_IRQ_MASK = 6'h21;

  // Field positions
  localparam int          SQS_VAR_RDY_BIT  = 15;
  localparam int          SQS_VAR_HOLD_BIT = 3;
  localparam int          SQS_LQM_ON_BIT   = 15;
  localparam int          SQS_FLAG_MSB     = 9;
  localparam int          SQS_IRQ_LQM_BIT  = 0;
  localparam int          SQS_IRQ_VAR_BIT  = 1;
  localparam int          SQS_IRQ_W        = 2;

  // Reset values
  localparam logic [31:0] SQS_VAR_SUM_RST  = 32'h0000_0000;
  localparam logic [9:0]  SQS_FLAGS_RST    = 10'h000;
  localparam logic [1:0]  SQS_IRQ_RST      = 2'h0;

  localparam logic [1:0]  SQS_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  SQS_RESP_SLVERR  = 2'h2;

  localparam logic [7:0]  SQS_PARAM_MAX    = 8'hff;
  localparam logic [7:0]  SQS_PARAM_MIN    = 8'h00;

  typedef struct packed {
    logic [SQS_PW-1:0] high;
    logic [SQS_PW-1:0] low;
  } sqs_thr_t;

  typedef sqs_thr_t [SQS_NPARAM-1:0]           sqs_thr_vec_t;
  typedef logic [SQS_NPARAM-1:0][SQS_PW-1:0]  sqs_param_vec_t;

endpackage

// file: hw/sqs_thr_check.sv
// Purpose: One high/low threshold comparison for a monitored parameter
// Assumes: Unsigned parameter and threshold values
// Notes:   Combinational; the caller registers the result
`timescale 1ns/10ps
module sqs_thr_check
  import sqs_pkg::*;
(
  input  wire logic [SQS_PW-1:0] i_value,
  input  wire sqs_thr_t          i_thr,
  output logic                   o_high,
  output logic                   o_low
);

  // Extreme thresholds can never be crossed, so they switch the check off
  assign o_high = (i_thr.high != SQS_PARAM_MAX) && (i_value > i_thr.high); // [R06]
  assign o_low  = (i_thr.low  != SQS_PARAM_MIN) && (i_value < i_thr.low);  // [R06]

endmodule

// file: hw/sqs_regs.sv
// Purpose: Variance sum readout and link quality monitor registers
// Assumes: Parameters, thresholds and variance results come from logic on i_clk
// Notes:   AXI4-Lite slave, one write and one read under way at most
//
// Contract
// [R01] The block keeps a 32-bit variance sum shown through a 16-bit read-only window.
// [R02] While the hold bit is set no new variance result is loaded into the sum.
// [R03] Software should set the hold bit once it sees the ready flag, before reading.
// [R04] After hold is set the first window read gives the low half, the second the high half.
// [R05] Bit 15 enables monitoring, which only runs while a valid 100 Mb/s link exists.
// [R06] A threshold set to its maximum or minimum value can never be violated.
// [R07] A threshold violation raises the interrupt only when its source is unmasked.
// [R08] Reading the monitor register clears every warning flag and re-arms the interrupt; the flag of a violation still present while active stays set.
// [R09] Warning flags are sticky high/low pairs at bits 9..0, one pair per parameter.
// [R10] Monitor bits 14:10 read as zero and ignore writes.
// [R11] Two consecutive window reads clear both the ready flag and the hold bit.
// [R12] A half pointer resets to the low half when hold is set and toggles on each read.
`timescale 1ns/10ps
module sqs_regs
  import sqs_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic              i_link_100_valid,
  input  wire sqs_param_vec_t    i_param,
  input  wire sqs_thr_vec_t      i_thr,
  input  wire logic              i_var_load,
  input  wire logic [31:0]       i_var_value,
  input  wire logic [SQS_AW-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [SQS_AW-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic                   o_irq
);

  logic [31:0]           var_sum;
  logic                  var_ready;
  logic                  var_hold;
  logic                  half_ptr;
  logic                  quality_monitor_on;
  logic [SQS_FLAG_MSB:0] flags;
  logic [SQS_IRQ_W-1:0]  irq_status;
  logic [SQS_IRQ_W-1:0]  irq_mask;
  logic [5:0]            aw_idx;
  logic                  aw_got;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  w_got;

  logic                  do_write;
  logic                  do_read;
  logic [5:0]            ar_idx;
  logic                  rd_window;
  logic                  rd_monitor;
  logic                  wr_var_ctrl;
  logic                  wr_monitor;
  logic                  wr_irq_stat;
  logic                  wr_irq_mask;
  logic                  hold_set;
  logic                  window_done;
  logic                  monitor_active;
  logic [SQS_FLAG_MSB:0] viol;
  logic [SQS_FLAG_MSB:0] next_flags;
  logic                  lqm_event;
  logic                  var_event;
  logic [SQS_IRQ_W-1:0]  next_irq_status;
  logic [31:0]           next_rdata;
  logic [1:0]            next_rresp;

  assign do_write    = aw_got && w_got && !o_bvalid;
  assign do_read     = i_arvalid && o_arready;
  assign ar_idx      = i_araddr[7:2];
  assign rd_window   = do_read && (ar_idx == SQS_IDX_VAR_WIN);
  assign rd_monitor  = do_read && (ar_idx == SQS_IDX_LQM);
  assign wr_var_ctrl = do_write && (aw_idx == SQS_IDX_VAR_CTRL) && w_strb[0];
  assign wr_monitor  = do_write && (aw_idx == SQS_IDX_LQM) && w_strb[1];
  assign wr_irq_stat = do_write && (aw_idx == SQS_IDX_IRQ_STAT) && w_strb[0];
  assign wr_irq_mask = do_write && (aw_idx == SQS_IDX_IRQ_MASK) && w_strb[0];
  assign hold_set    = wr_var_ctrl && w_data[SQS_VAR_HOLD_BIT];
  assign window_done = rd_window && half_ptr;

  // Threshold comparators, one per monitored parameter
  genvar g;
  generate
    for (g = 0; g < SQS_NPARAM; g++)
    begin : g_chk
      sqs_thr_check u_chk
      (
        .i_value (i_param[g]),
        .i_thr   (i_thr[g]),
        .o_high  (viol[2*g+1]),
        .o_low   (viol[2*g])
      );
    end
  endgenerate

  assign monitor_active = quality_monitor_on && i_link_100_valid;               // [R05]

  // Only a flag going from clear to set counts, so a standing violation
  // interrupts once until the monitor register is read again; the read
  // itself counts as clear so a persisting violation re-arms at once
  assign lqm_event = monitor_active &&
                     |(viol & ~(rd_monitor ? SQS_FLAGS_RST : flags));           // [R08]
  assign var_event = i_ce && i_var_load && !var_hold;

  always_comb
  begin
    next_flags = flags;
    if (rd_monitor)
    begin
      next_flags = SQS_FLAGS_RST;                                               // [R08]
    end
    if (monitor_active)
    begin
      next_flags = next_flags | viol;                                           // [R09]
    end
  end

  always_comb
  begin
    next_irq_status = irq_status;
    if (wr_irq_stat)
    begin
      next_irq_status = irq_status & ~w_data[SQS_IRQ_W-1:0];
    end
    // Set beats a simultaneous clear
    if (lqm_event)
    begin
      next_irq_status[SQS_IRQ_LQM_BIT] = 1'b1;
    end
    if (var_event)
    begin
      next_irq_status[SQS_IRQ_VAR_BIT] = 1'b1;
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = SQS_RESP_OKAY;
    case (ar_idx)
      SQS_IDX_VAR_CTRL:
      begin
        next_rdata[SQS_VAR_RDY_BIT]  = var_ready;
        next_rdata[SQS_VAR_HOLD_BIT] = var_hold;
      end
      SQS_IDX_VAR_WIN:
      begin
        next_rdata[15:0] = half_ptr ? var_sum[31:16] : var_sum[15:0];           // [R04]
      end
      SQS_IDX_LQM:
      begin
        // Bits 14:10 stay zero
        next_rdata[SQS_LQM_ON_BIT]   = quality_monitor_on;                      // [R10]
        next_rdata[SQS_FLAG_MSB:0]   = flags;
      end
      SQS_IDX_IRQ_STAT:
      begin
        next_rdata[SQS_IRQ_W-1:0] = irq_status;
      end
      SQS_IDX_IRQ_MASK:
      begin
        next_rdata[SQS_IRQ_W-1:0] = irq_mask;
      end
      default:
      begin
        next_rresp = SQS_RESP_SLVERR;
      end
    endcase
  end

  // Write address channel
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_awready <= 1'b1;
      aw_got    <= 1'b0;
      aw_idx    <= 6'h00;
    end
    else if (i_ce)
    begin
      if (i_awvalid && o_awready)
      begin
        o_awready <= 1'b0;
        aw_got    <= 1'b1;
        aw_idx    <= i_awaddr[7:2];
      end
      else if (do_write)
      begin
        aw_got <= 1'b0;
      end
      else if (o_bvalid && i_bready)
      begin
        o_awready <= 1'b1;
      end
    end
  end

  // Write data channel
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_wready <= 1'b1;
      w_got    <= 1'b0;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
    end
    else if (i_ce)
    begin
      if (i_wvalid && o_wready)
      begin
        o_wready <= 1'b0;
        w_got    <= 1'b1;
        w_data   <= i_wdata;
        w_strb   <= i_wstrb;
      end
      else if (do_write)
      begin
        w_got <= 1'b0;
      end
      else if (o_bvalid && i_bready)
      begin
        o_wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped writes are answered with an error and dropped
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= SQS_RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (do_write)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= (aw_idx == SQS_IDX_VAR_CTRL || aw_idx == SQS_IDX_VAR_WIN ||
                     aw_idx == SQS_IDX_LQM || aw_idx == SQS_IDX_IRQ_STAT ||
                     aw_idx == SQS_IDX_IRQ_MASK) ? SQS_RESP_OKAY : SQS_RESP_SLVERR;
      end
      else if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; side effects happen when the address is taken
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= SQS_RESP_OKAY;
    end
    else if (i_ce)
    begin
      if (do_read)
      begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rdata   <= next_rdata;
        o_rresp   <= next_rresp;
      end
      else if (o_rvalid && i_rready)
      begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // Variance sum and ready flag
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      var_sum   <= SQS_VAR_SUM_RST;
      var_ready <= 1'b0;
    end
    else if (i_ce)
    begin
      if (var_event)
      begin
        var_sum   <= i_var_value;                                               // [R01] [R02]
        var_ready <= 1'b1;
      end
      else if (window_done)
      begin
        var_ready <= 1'b0;                                                      // [R11]
      end
    end
  end

  // Hold bit; a fresh set from software wins over the automatic clear
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      var_hold <= 1'b0;
    end
    else if (i_ce)
    begin
      if (wr_var_ctrl)
      begin
        var_hold <= w_data[SQS_VAR_HOLD_BIT];                                   // [R03]
      end
      else if (window_done)
      begin
        var_hold <= 1'b0;                                                       // [R11]
      end
    end
  end

  // Half pointer
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      half_ptr <= 1'b0;
    end
    else if (i_ce)
    begin
      if (hold_set)
      begin
        half_ptr <= 1'b0;                                                       // [R12]
      end
      else if (rd_window)
      begin
        half_ptr <= ~half_ptr;                                                  // [R12] [R04]
      end
    end
  end

  // Monitor enable and warning flags
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      quality_monitor_on <= 1'b0;
      flags              <= SQS_FLAGS_RST;
    end
    else if (i_ce)
    begin
      if (wr_monitor)
      begin
        quality_monitor_on <= w_data[SQS_LQM_ON_BIT];                           // [R05]
      end
      flags <= next_flags;                                                      // [R09]
    end
  end

  // Interrupt status, mask and output
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      irq_status <= SQS_IRQ_RST;
      irq_mask   <= SQS_IRQ_RST;
      o_irq      <= 1'b0;
    end
    else if (i_ce)
    begin
      irq_status <= next_irq_status;
      if (wr_irq_mask)
      begin
        irq_mask <= w_data[SQS_IRQ_W-1:0];
      end
      o_irq <= |(next_irq_status & irq_mask);                                   // [R07]
    end
  end

endmodule

// file: testbench/sqs_regs_sva.sv
// Purpose: Port-level checks on the signal quality register block
// Assumes: One clock domain, byte address is four times the word index
// Notes:   Sees only top-level ports; bound from the bench top file
`timescale 1ns/10ps
module sqs_regs_sva
  import sqs_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire sqs_param_vec_t    i_param,
  input  wire sqs_thr_vec_t      i_thr,
  input  wire logic              i_var_load,
  input  wire logic              i_awvalid,
  input  wire logic              o_awready,
  input  wire logic              i_wvalid,
  input  wire logic              o_wready,
  input  wire logic [1:0]        o_bresp,
  input  wire logic              o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [SQS_AW-1:0] i_araddr,
  input  wire logic              i_arvalid,
  input  wire logic              o_arready,
  input  wire logic [31:0]       o_rdata,
  input  wire logic [1:0]        o_rresp,
  input  wire logic              o_rvalid,
  input  wire logic              i_rready,
  input  wire logic              o_irq
);
  logic [7:0] ar_q;
  logic [2:0] quiet;
  logic       viol;
  // Superset of real causes: enable and link are not visible here
  always_comb
  begin
    viol = 1'b0;
    for (int k = 0; k < SQS_NPARAM; k++)
      viol |= (i_param[k] > i_thr[k].high) || (i_param[k] < i_thr[k].low);
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      ar_q <= 8'h00;
    else if (i_arvalid && o_arready)
      ar_q <= i_araddr;
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      quiet <= 3'h7;
    else if (viol || i_var_load || (i_wvalid && o_wready) || (i_awvalid && o_awready))
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_B_STABLE: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  AST_R_STABLE: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data changed early");
  AST_AR_BLOCK: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while answer pending");
  AST_W_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while response pending");
  AST_B_LAT: assert property ($rose(o_bvalid) |->
    $past((i_awvalid && o_awready) || (i_wvalid && o_wready), 2))
    else $error("write response at wrong time");
  AST_R_LAT: assert property ($rose(o_rvalid) |-> $past(i_arvalid && o_arready))
    else $error("read answer at wrong time");
  AST_WIN_UPPER: assert property (
    o_rvalid && ar_q == {SQS_IDX_VAR_WIN, 2'b00} |-> o_rdata[31:16] == 16'h0000)
    else $error("window upper bits not zero");
  AST_MON_RSVD: assert property (
    o_rvalid && ar_q == {SQS_IDX_LQM, 2'b00} |-> o_rdata[31:16] == 16'h0000 &&
    o_rdata[14:10] == 5'h00)
    else $error("monitor reserved bits not zero");
  AST_IRQ_CAUSE: assert property ($rose(o_irq) |-> quiet <= 3'h4)
    else $error("interrupt rose without a cause");
endmodule

// file: testbench/sqs_regs_bench.sv
// Purpose: Self-checking bench for the signal quality register block
// Assumes: Clock enable driven by the bench, ready signals held high by the master
// Notes:   Read answers are checked from a queue of expected values
`timescale 1ns/10ps
module sqs_regs_bench
  import sqs_pkg::*;
;
  localparam logic [7:0] A_CTRL = {SQS_IDX_VAR_CTRL, 2'b00};
  localparam logic [7:0] A_WIN  = {SQS_IDX_VAR_WIN, 2'b00};
  localparam logic [7:0] A_MON  = {SQS_IDX_LQM, 2'b00};
  localparam logic [7:0] A_STAT = {SQS_IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] A_MASK = {SQS_IDX_IRQ_MASK, 2'b00};
  logic           i_clk, i_rst_n, i_ce, i_var_load, i_link_100_valid;
  logic [31:0]    i_var_value, i_wdata, o_rdata, v;
  logic [7:0]     i_awaddr, i_araddr;
  logic           i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic           o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0]     o_bresp, o_rresp;
  logic [3:0]     i_wstrb;
  sqs_param_vec_t i_param;
  sqs_thr_vec_t   i_thr;
  logic [33:0]    exp_q[$];
  int             num_errors, n_checks, cycles;
  integer         seed;
  sqs_regs u_sqs_regs (.i_clk, .i_rst_n, .i_ce, .i_link_100_valid, .i_param, .i_thr,
    .i_var_load, .i_var_value, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_irq);
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] want);
    n_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [33:0] ok(input logic [31:0] d);
    return {SQS_RESP_OKAY, d};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic a_done, w_done;
    a_done = 1'b0;
    w_done = 1'b0;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    while (!(a_done && w_done))
    begin
      @(posedge i_clk);
      a_done |= o_awready;
      w_done |= o_wready;
      if (a_done) i_awvalid <= 1'b0;
      if (w_done) i_wvalid <= 1'b0;
    end
    do @(posedge i_clk); while (o_bvalid !== 1'b1);
    chk({32'h0, o_bresp}, {32'h0, r});
  endtask
  // Expected answer queued first so the watcher never races the driver
  task automatic rd(input logic [7:0] a, input logic [33:0] want);
    exp_q.push_back(want);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (o_rvalid !== 1'b1);
  endtask
  task automatic load(input logic [31:0] d);
    i_var_value <= d;
    i_var_load <= 1'b1;
    tick(1);
    i_var_load <= 1'b0;
    tick(1);
  endtask
  task automatic pulse(input int k, input logic [7:0] p);
    i_param[k] <= p;
    tick(2);
    i_param[k] <= 8'h80;
    tick(2);
  endtask
  always @(posedge i_clk)
    if (o_rvalid && i_rready && exp_q.size() > 0)
      chk({o_rresp, o_rdata}, exp_q.pop_front());
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    seed = 32'hbb1f;
    i_rst_n = 1'b0;
    i_var_load = 1'b0;
    i_var_value = 32'h0000_0000;
    i_link_100_valid = 1'b1;
    i_ce = 1'b1;
    i_awaddr = 8'h00;
    i_araddr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wstrb = 4'hf;
    {i_awvalid, i_wvalid, i_arvalid} = 3'h0;
    {i_bready, i_rready} = 2'h3;
    for (int k = 0; k < SQS_NPARAM; k++)
    begin
      i_param[k] = 8'h80;
      i_thr[k] = '{high: 8'hc0, low: 8'h40};
    end
    tick(6);
    i_rst_n <= 1'b1;
    tick(1);
    rd(A_WIN, ok(32'h0));
    rd(A_MON, ok(32'h0));
    rd(A_CTRL, ok(32'h0));
    rd(8'h90, {SQS_RESP_SLVERR, 32'h0});
    wr(8'h90, 32'hffff_ffff, SQS_RESP_SLVERR);
    v = $random(seed);
    load(v);
    rd(A_CTRL, ok(32'h8000));
    wr(A_CTRL, 32'h8, SQS_RESP_OKAY);
    load(~v);
    rd(A_WIN, ok({16'h0, v[15:0]}));
    rd(A_WIN, ok({16'h0, v[31:16]}));
    rd(A_CTRL, ok(32'h0));
    v = $random(seed);
    load(v);
    wr(A_CTRL, 32'h8, SQS_RESP_OKAY);
    rd(A_WIN, ok({16'h0, v[15:0]}));
    wr(A_CTRL, 32'h8, SQS_RESP_OKAY);
    rd(A_WIN, ok({16'h0, v[15:0]}));
    rd(A_WIN, ok({16'h0, v[31:16]}));
    wr(A_MON, 32'hffff, SQS_RESP_OKAY);
    rd(A_MON, ok(32'h8000));
    wr(A_MASK, 32'h1, SQS_RESP_OKAY);
    for (int b = 0; b < 10; b++)
    begin
      pulse(b / 2, b[0] ? 8'hc1 : 8'h3f);
      rd(A_MON, ok(32'h8000 | (32'h1 << b)));
    end
    rd(A_MON, ok(32'h8000));
    chk({33'h0, o_irq}, {33'h0, 1'b1});
    rd(A_STAT, ok(32'h3));
    wr(A_STAT, 32'h3, SQS_RESP_OKAY);
    tick(2);
    chk({33'h0, o_irq}, 34'h0);
    wr(A_MASK, 32'h0, SQS_RESP_OKAY);
    pulse(4, 8'hc1);
    chk({33'h0, o_irq}, 34'h0);
    rd(A_STAT, ok(32'h1));
    rd(A_MON, ok(32'h8200));
    i_link_100_valid <= 1'b0;
    pulse(1, 8'h3f);
    i_link_100_valid <= 1'b1;
    wr(A_MON, 32'h0, SQS_RESP_OKAY);
    pulse(3, 8'hc1);
    wr(A_MON, 32'h8000, SQS_RESP_OKAY);
    rd(A_MON, ok(32'h8000));
    // Extreme thresholds: nothing can lie beyond them
    i_thr[2] <= '{high: 8'hff, low: 8'h00};
    pulse(2, 8'hff);
    pulse(2, 8'h00);
    rd(A_MON, ok(32'h8000));
    // Standing violation: no new interrupt until the monitor read re-arms it
    i_param[0] <= 8'h3f;
    wr(A_STAT, 32'h1, SQS_RESP_OKAY);
    rd(A_STAT, ok(32'h0));
    rd(A_MON, ok(32'h8001));
    rd(A_STAT, ok(32'h1));
    i_param[0] <= 8'h80;
    rd(A_MON, ok(32'h8001));
    rd(A_MON, ok(32'h8000));
    // Clock enable low freezes the sum; window writes change nothing
    i_ce <= 1'b0;
    load(~v);
    i_ce <= 1'b1;
    rd(A_CTRL, ok(32'h0));
    wr(A_WIN, 32'hffff_ffff, SQS_RESP_OKAY);
    rd(A_WIN, ok({16'h0, v[15:0]}));
    summarize();
  end
endmodule
bind sqs_regs sqs_regs_sva u_sqs_regs_sva (.i_clk, .i_rst_n, .i_param, .i_thr, .i_var_load,
  .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
  .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_irq);
